// File: dtb_defines.vh
`ifndef DTB_DEFINES_VH
`define DTB_DEFINES_VH
// APB register byte offsets
`define DTB_OFF_CMD       12'h000
`define DTB_OFF_STATUS    12'h004
`define DTB_OFF_CLEAR     12'h008
`define DTB_OFF_IRQ_EN    12'h00C
`define DTB_OFF_NVCFG     12'h010
`define DTB_OFF_PINSEL    12'h014
`define DTB_OFF_ANALOG    12'h018
// Command codes
`define DTB_CMD_DIGITAL   8'h18
`define DTB_CMD_ANALOG    8'h19
// Group codes
`define DTB_GRP_CLOCK     8'h01
`define DTB_GRP_TX        8'h1B
`define DTB_GRP_TIMER     8'h1D
`define DTB_GRP_CARD      8'h30
`define DTB_GRP_TRX       8'h58
`define DTB_GRP_RXDATA    8'h70
`define DTB_GRP_RXERR     8'h73
// Signal selection value and maximum pin byte count
`define DTB_SEL_CARRIER   4'h8
`define DTB_NUM_PINS_MAX  3'h4
// Nonvolatile enable bit position
`define DTB_NV_ENABLE_BIT 7
// Status bits
`define DTB_ST_DIGITAL    0
`define DTB_ST_ANALOG     1
`define DTB_ST_BADCMD     2
`endif

// File: dtb_host.sv
`timescale 1ns/1ps
`default_nettype none
module dtb_host (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  logic [31:0] rd_q;
  logic        err_q;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pin bytes first: the command latches whatever is staged
  task automatic dig(input logic [7:0] grp, input logic [31:0] pins, input logic [2:0] n);
    xfer(1'b1, 12'h014, pins);
    xfer(1'b1, 12'h000, {8'h00, grp, 5'h00, n, 8'h18});
  endtask
endmodule
`default_nettype wire

// File: dtb_mux.v
`timescale 1ns/1ps
`default_nettype none
`include "dtb_defines.vh"
module dtb_mux (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        carrier_clk,
  input  wire [1:0]  tx_sig,
  input  wire [5:0]  timer_sig,
  input  wire [7:0]  card_mode_sig,
  input  wire [7:0]  trx_sig,
  input  wire [7:0]  rx_data_sig,
  input  wire [7:0]  rx_err_sig,
  input  wire [7:0]  clk_grp_sig,
  output reg         irq_pin_out,
  output reg         aux_out_one,
  output reg         aux_out_two,
  output reg         general_out_one,
  output reg  [3:0]  pin_drive_en,
  output wire [7:0]  analog_sel_one,
  output wire [7:0]  analog_sel_two,
  output wire        analog_en,
  output wire        irq
);

  // ----------------------------------------
  // Configuration state
  // ----------------------------------------
  reg  [7:0]  grp_r   [0:3];
  reg  [3:0]  sel_r   [0:3];
  reg  [3:0]  valid_r;
  reg  [7:0]  nvcfg_r;
  reg  [7:0]  an_one_r;
  reg  [7:0]  an_two_r;
  reg         an_en_r;
  reg  [2:0]  status_r;
  reg  [2:0]  irq_en_r;
  reg  [2:0]  ev_set;
  reg  [2:0]  ev_clr;
  reg  [31:0] pin_bytes_r;
  integer     j;

  wire        wr_acc = psel & penable & pwrite;
  wire        rd_acc = psel & penable & ~pwrite;
  wire        bus_en = nvcfg_r[`DTB_NV_ENABLE_BIT];
  wire [7:0]  cmd    = pwdata[7:0];
  wire        is_cmd = wr_acc && (paddr == `DTB_OFF_CMD);
  wire [2:0]  npar   = pwdata[10:8];

  assign pready         = 1'b1;
  assign pslverr        = (psel & penable) & ~known(paddr);
  assign analog_sel_one = an_one_r;
  assign analog_sel_two = an_two_r;
  assign analog_en      = an_en_r & bus_en;
  assign irq            = |(status_r & irq_en_r);

  function known;
    input [11:0] a;
    begin
      case (a)
        `DTB_OFF_CMD,
        `DTB_OFF_STATUS,
        `DTB_OFF_CLEAR,
        `DTB_OFF_IRQ_EN,
        `DTB_OFF_NVCFG,
        `DTB_OFF_PINSEL,
        `DTB_OFF_ANALOG: known = 1'b1;
        default:         known = 1'b0;
      endcase
    end
  endfunction

  function grp_ok;
    input [7:0] g;
    begin
      case (g)
        `DTB_GRP_CLOCK,
        `DTB_GRP_TX,
        `DTB_GRP_TIMER,
        `DTB_GRP_CARD,
        `DTB_GRP_TRX,
        `DTB_GRP_RXDATA,
        `DTB_GRP_RXERR: grp_ok = 1'b1;
        default:        grp_ok = 1'b0;
      endcase
    end
  endfunction

  // Per-byte decode of the pin selection bytes
  function [1:0] pin_of;
    input [7:0] b;
    begin
      pin_of = b[5:4];
    end
  endfunction

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // CMD word: [7:0] code, [10:8] byte count (1..4), [15:8] second analog
  // byte when code is analog; pin bytes live in PINSEL, group in [23:16].
  reg        dig_ok;
  reg [3:0]  hit;
  wire [7:0] pin_byte [0:3];
  reg        pin_bad;
  integer    k;
  genvar     gb;

  // Unpacked once; decode and update both index it
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_byte
      assign pin_byte[gb] = pin_bytes_r[gb*8 +: 8];
    end
  endgenerate

  // Checked every cycle; only a command acts on the result
  always @* begin
    hit     = 4'h0;
    pin_bad = 1'b0;
    for (k = 0; k < 4; k = k + 1) begin
      if (k[2:0] < npar) begin
        if (pin_byte[k][7:6] != 2'b00) begin
          pin_bad = 1'b1;
        end else begin
          hit[pin_of(pin_byte[k])] = 1'b1;
        end
      end
    end
  end

  always @* begin
    dig_ok = 1'b0;
    ev_set = 3'h0;
    if (is_cmd && (cmd == `DTB_CMD_DIGITAL)) begin
      dig_ok = grp_ok(pwdata[23:16]) && (npar != 3'h0) &&
               (npar <= `DTB_NUM_PINS_MAX);
      if (dig_ok && !pin_bad) begin
        ev_set[`DTB_ST_DIGITAL] = 1'b1;
      end else begin
        ev_set[`DTB_ST_BADCMD] = 1'b1;
      end
    end else if (is_cmd && (cmd == `DTB_CMD_ANALOG)) begin
      ev_set[`DTB_ST_ANALOG] = 1'b1;
    end else if (is_cmd) begin
      ev_set[`DTB_ST_BADCMD] = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @* begin
    ev_clr = 3'h0;
    if (wr_acc && (paddr == `DTB_OFF_CLEAR)) begin
      ev_clr = pwdata[2:0];
    end
  end

  // Sticky; an event in the clear's cycle still lands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= 3'h0;
    end else begin
      status_r <= (status_r & ~ev_clr) | ev_set;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= 3'h0;
    end else if (wr_acc && (paddr == `DTB_OFF_IRQ_EN)) begin
      irq_en_r <= pwdata[2:0];
    end
  end

  // Volatile stand-in for the nonvolatile enable byte
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvcfg_r <= 8'h00;
    end else if (wr_acc && (paddr == `DTB_OFF_NVCFG)) begin
      nvcfg_r <= pwdata[7:0];
    end
  end

  // Staged only; a later command applies the bytes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_bytes_r <= 32'h0000_0000;
    end else if (wr_acc && (paddr == `DTB_OFF_PINSEL)) begin
      pin_bytes_r <= pwdata;
    end
  end

  // ----------------------------------------
  // Pin configuration
  // ----------------------------------------
  // A rejected command leaves every pin as it was
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (j = 0; j < 4; j = j + 1) begin
        grp_r[j] <= 8'h00;
        sel_r[j] <= 4'h0;
      end
      valid_r <= 4'h0;
    end else if (ev_set[`DTB_ST_DIGITAL]) begin
      for (j = 0; j < 4; j = j + 1) begin
        if (hit[j]) begin
          grp_r[j]   <= pwdata[23:16];
          valid_r[j] <= 1'b1;
        end
      end
      for (j = 0; j < 4; j = j + 1) begin
        if (j[2:0] < npar) begin
          sel_r[pin_of(pin_byte[j])] <= pin_byte[j][3:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Analog probe selection
  // ----------------------------------------
  // Selections show at once; analog_en still waits for the bus enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      an_one_r <= 8'h00;
      an_two_r <= 8'h00;
      an_en_r  <= 1'b0;
    end else if (ev_set[`DTB_ST_ANALOG]) begin
      an_two_r <= pwdata[15:8];
      an_one_r <= pwdata[23:16];
      an_en_r  <= 1'b1;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      case (paddr)
        `DTB_OFF_STATUS: prdata = {29'h0, status_r};
        `DTB_OFF_IRQ_EN: prdata = {29'h0, irq_en_r};
        `DTB_OFF_NVCFG:  prdata = {24'h0, nvcfg_r};
        `DTB_OFF_PINSEL: prdata = pin_bytes_r;
        `DTB_OFF_ANALOG: prdata = {15'h0, an_en_r, an_one_r, an_two_r};
        default:         prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Signal selection per group
  // ----------------------------------------
  function pick;
    input [7:0] g;
    input [3:0] s;
    input       cc;
    input [1:0] tx;
    input [5:0] tm;
    input [7:0] cm;
    input [7:0] tr;
    input [7:0] rd;
    input [7:0] re;
    input [7:0] ck;
    begin
      // Reserved nibbles and unknown groups read low while driven
      pick = 1'b0;
      if (s == `DTB_SEL_CARRIER) begin
        pick = cc;
      end else if (s[3] == 1'b0) begin
        case (g)
          `DTB_GRP_CLOCK:  pick = ck[s[2:0]];
          `DTB_GRP_TX:     pick = (s[2:1] == 2'b00) ? tx[s[0]] : 1'b0;
          // tm: [5]=t0 run [4]=t0 exp [3]=t1 run [2]=t1 exp [1]=t2 run [0]=t2 exp
          `DTB_GRP_TIMER:  pick = (s[2:1] != 2'b00) ? tm[s[2:0] - 3'h2] : 1'b0;
          `DTB_GRP_CARD:   pick = cm[s[2:0]];
          `DTB_GRP_TRX:    pick = tr[s[2:0]];
          `DTB_GRP_RXDATA: pick = rd[s[2:0]];
          `DTB_GRP_RXERR:  pick = (s[2:0] >= 3'h3 && s[2:0] <= 3'h5) ? 1'b0 : re[s[2:0]];
          default:         pick = 1'b0;
        endcase
      end
    end
  endfunction

  // Outputs registered; carrier selection thus lags one pclk and is
  // only meaningful when pclk is fast relative to the carrier.
  wire [3:0] pin_val;
  genvar     gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      assign pin_val[gi] = pick(grp_r[gi], sel_r[gi], carrier_clk, tx_sig, timer_sig,
                                card_mode_sig, trx_sig, rx_data_sig, rx_err_sig, clk_grp_sig);
    end
  endgenerate

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  wire [3:0] pin_on = valid_r & {4{bus_en}};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pin_out     <= 1'b0;
      aux_out_one     <= 1'b0;
      aux_out_two     <= 1'b0;
      general_out_one <= 1'b0;
      pin_drive_en    <= 4'h0;
    end else begin
      pin_drive_en    <= pin_on;
      irq_pin_out     <= pin_val[0] & pin_on[0];
      aux_out_one     <= pin_val[1] & pin_on[1];
      aux_out_two     <= pin_val[2] & pin_on[2];
      general_out_one <= pin_val[3] & pin_on[3];
    end
  end

endmodule
`default_nettype wire

// File: dtb_mux_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dtb_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        analog_en,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pin_drive_en
);
  logic nv_en_r;
  wire  acc = psel && penable;
  // Shadow of the enable bit, updated at the same edge as the design's copy
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) nv_en_r <= 1'b0;
    else if (acc && pwrite && paddr == 12'h010) nv_en_r <= pwdata[7];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  zero_wait_a: assert property (acc |-> pready) else $error("pready low in access");
  unmapped_err_a: assert property (acc && paddr > 12'h018 |-> pslverr) else $error("no error on unmapped");
  mapped_ok_a: assert property (acc && paddr == 12'h014 |-> !pslverr) else $error("error on mapped");
  setup_quiet_a: assert property (psel && !penable |-> !pslverr) else $error("error in setup");
  bus_off_a: assert property (!nv_en_r && !$past(nv_en_r) |-> pin_drive_en == 4'h0) else $error("pin driven");
  analog_off_a: assert property (!nv_en_r && !$past(nv_en_r) |-> !analog_en) else $error("analog on");
  reset_clear_a: assert property ($rose(presetn) |-> pin_drive_en == 4'h0 && !analog_en) else $error("not clear");
  sel_hold_a: assert property ($changed(pin_drive_en) |-> $past(acc && pwrite, 2)) else $error("drive changed");
  cover property (acc && pslverr);
  cover property (pin_drive_en == 4'hF);
  cover property ($rose(analog_en));
endmodule
bind dtb_mux dtb_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .analog_en,
  .paddr, .pwdata, .pin_drive_en);
`default_nettype wire

// File: tb_debug_signal_test_bus_mux.sv
`timescale 1ns/1ps
`default_nettype none
module tb_debug_signal_test_bus_mux;
  logic pclk = 0, presetn = 0, carrier_clk = 0;
  logic [1:0] tx_sig = 0;
  logic [5:0] timer_sig = 0;
  logic [7:0] card_mode_sig = 0, trx_sig = 0, rx_data_sig = 0, rx_err_sig = 0, clk_grp_sig = 0;
  wire logic psel, penable, pwrite, pready, pslverr, irq_pin_out, aux_out_one, aux_out_two;
  wire logic general_out_one, analog_en, irq;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic [3:0] pin_drive_en;
  wire logic [7:0] analog_sel_one, analog_sel_two;
  int num_errors = 0, n_checks = 0;
  // Row: group, selection, reserved, level seen with the base pattern
  logic [13:0] rows [20] = '{{8'h1B,4'h1,2'b01}, {8'h1B,4'h0,2'b00}, {8'h1B,4'h3,2'b10}, {8'h1D,4'h7,2'b01},
    {8'h1D,4'h6,2'b00}, {8'h1D,4'h2,2'b01}, {8'h1D,4'h0,2'b10}, {8'h30,4'h6,2'b00}, {8'h30,4'h5,2'b01},
    {8'h30,4'h7,2'b01}, {8'h30,4'h1,2'b00}, {8'h30,4'h8,2'b01}, {8'h58,4'h5,2'b01}, {8'h58,4'h1,2'b00},
    {8'h70,4'h7,2'b01}, {8'h70,4'h3,2'b00}, {8'h73,4'h6,2'b01}, {8'h73,4'h4,2'b10}, {8'h73,4'h9,2'b10},
    {8'h01,4'h1,2'b01}};
  always #25 pclk = ~pclk;
  dtb_mux i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .carrier_clk, .tx_sig, .timer_sig, .card_mode_sig, .trx_sig, .rx_data_sig, .rx_err_sig, .clk_grp_sig,
    .irq_pin_out, .aux_out_one, .aux_out_two, .general_out_one, .pin_drive_en, .analog_sel_one,
    .analog_sel_two, .analog_en, .irq);
  dtb_host i_host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk("reset", {analog_en, irq, pin_drive_en}, 0);
    i_host.dig(8'h1D, 32'h17, 3'd1);
    i_host.xfer(1'b1, 12'h000, 32'h00A1B219);
    settle;
    chk("gated", {analog_en, pin_drive_en}, 0);
    i_host.xfer(1'b1, 12'h010, 32'h80);
    settle;
    chk("enabled", {analog_en, pin_drive_en}, 5'h12);
    $display("enable test done");
    for (int p = 0; p < 2; p++) begin
      @(posedge pclk);
      {carrier_clk, tx_sig, timer_sig, card_mode_sig, trx_sig, rx_data_sig, rx_err_sig, clk_grp_sig} <=
        {1'b1, 2'b10, 6'b101001, 8'hA5, 8'h3C, 8'h96, 8'hC3, 8'h5A} ^ {49{p[0]}};
      foreach (rows[i]) begin
        i_host.dig(rows[i][13:6], {24'h0, 4'h1, rows[i][5:2]}, 3'd1);
        settle;
        chk("aux_out_one", {pin_drive_en[1], aux_out_one}, {1'b1, ~rows[i][1] & (rows[i][0] ^ p[0])});
      end
      $display("table pass %0d done", p);
    end
    i_host.dig(8'h1D, 32'h33261806, 3'd4);
    settle;
    chk("four pins", {pin_drive_en, irq_pin_out, aux_out_one, aux_out_two, general_out_one}, 8'hFB);
    i_host.dig(8'h1D, 32'h47, 3'd1);
    i_host.dig(8'h44, 32'h17, 3'd1);
    settle;
    chk("held", pin_drive_en, 4'hF);
    i_host.xfer(1'b0, 12'h004, 0);
    chk("bad cmd", i_host.rd_q[2], 1'b1);
    i_host.xfer(1'b1, 12'h00C, 32'h4);
    settle;
    chk("irq on", irq, 1'b1);
    i_host.xfer(1'b1, 12'h00C, 32'h0);
    settle;
    chk("irq masked", irq, 1'b0);
    i_host.xfer(1'b1, 12'h00C, 32'h4);
    i_host.xfer(1'b1, 12'h008, 32'h4);
    settle;
    chk("irq cleared", irq, 1'b0);
    $display("error and irq test done");
    i_host.xfer(1'b1, 12'h000, 32'h00C3D419);
    settle;
    chk("analog", {analog_en, analog_sel_one, analog_sel_two}, 17'h1C3D4);
    i_host.xfer(1'b0, 12'h018, 0);
    chk("analog reg", i_host.rd_q, 32'h0001C3D4);
    i_host.xfer(1'b0, 12'h01C, 0);
    chk("unmapped", {i_host.err_q, i_host.rd_q}, 33'h100000000);
    i_host.xfer(1'b1, 12'h010, 32'h0);
    settle;
    chk("disabled", {analog_en, pin_drive_en}, 0);
    i_host.xfer(1'b1, 12'h010, 32'h80);
    @(posedge pclk);
    presetn <= 1'b0;
    settle;
    @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk("mid reset", {analog_en, pin_drive_en}, 0);
    $display("analog and reset test done");
    give_verdict;
  end
  initial begin
    repeat (6000) @(posedge pclk);
    num_errors++;
    give_verdict;
  end
endmodule
`default_nettype wire
